// >>> src/dofr_pkg.sv
package dofr_pkg;
    // ==========================================================
    // Widths
    localparam int DATA_W = 32;
    localparam int GUARD_W = 8;
    localparam int ACC_W = 40;
    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_SR = 8'h00;
    localparam logic [7:0] ADDR_CR = 8'h04;
    localparam logic [7:0] ADDR_VBR = 8'h08;
    localparam logic [7:0] ADDR_ACCLO = 8'h0C;
    localparam logic [7:0] ADDR_ACCG = 8'h10;
    localparam logic [7:0] ADDR_PC = 8'h14;
    localparam logic [7:0] ADDR_SP = 8'h18;
    // ==========================================================
    // Condition register fields
    localparam int CR_GT = 7;
    localparam int CR_Z = 6;
    localparam int CR_N = 5;
    localparam int CR_V = 4;
    localparam int CR_CS = 1;
    localparam int CR_DC = 0;
    localparam logic [31:0] CR_RST = 32'h0000_0000;
    // ==========================================================
    // Core status register fields
    localparam int SR_IMASK = 4;
    localparam int SR_RFL = 2;
    localparam int SR_RFH = 3;
    localparam int SR_XMOD = 10;
    localparam int SR_YMOD = 11;
    localparam int SR_RC = 16;
    localparam logic [31:0] SR_RST = 32'h0000_00F0;
    localparam logic [31:0] SR_WMASK = 32'h0FFF_0CFF;
    localparam logic [31:0] VBR_RST = 32'h0000_0000;
    // ==========================================================
    // Vector table and shift limits
    localparam logic [31:0] VEC_PC_ADDR = 32'h0000_0000;
    localparam logic [31:0] VEC_SP_ADDR = 32'h0000_0004;
    localparam int ASH_MIN = -32;
    localparam int ASH_MAX = 32;
    localparam int LSH_MIN = -16;
    localparam int LSH_MAX = 16;
    // ==========================================================
    // Encodings
    localparam logic [1:0] OP_ADD = 2'h0;
    localparam logic [1:0] OP_SUB = 2'h1;
    localparam logic [1:0] OP_ASH = 2'h2;
    localparam logic [1:0] OP_LSH = 2'h3;
    localparam logic [1:0] FMT_FIX = 2'h0;
    localparam logic [1:0] FMT_INT = 2'h1;
    localparam logic [1:0] FMT_LOG = 2'h2;
    localparam logic [1:0] SZ_B = 2'h0;
    localparam logic [1:0] SZ_W = 2'h1;
    localparam logic [1:0] SZ_L = 2'h2;
    typedef enum logic [1:0] {DOFR_BOOT_PC, DOFR_BOOT_SP, DOFR_RUN} dofr_state_t;
    typedef struct packed {
        dofr_state_t st;
        logic [31:0] sr;
        logic [31:0] cr;
        logic [31:0] vector_base_register;
        logic [39:0] acc;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [31:0] rdata;
        logic [31:0] ld;
        logic addrErr;
        logic [31:0] imm;
        logic [31:0] lit;
        logic shiftBad;
    } dofr_st_t;
endpackage

// >>> src/dofr_unit.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dofr_unit
    import dofr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic vecRd,
    output logic [31:0] vecAddr,
    input wire logic vecAck,
    input wire logic [31:0] vecData,
    output logic bootDone,
    input wire logic opValid,
    input wire logic [1:0] opCode,
    input wire logic [1:0] opFmt,
    input wire logic [31:0] srcA,
    input wire logic [7:0] srcAGuard,
    input wire logic srcAIsAcc,
    input wire logic [31:0] srcB,
    output logic [39:0] accOut,
    output logic [31:0] crOut,
    output logic [31:0] srOut,
    output logic shiftBad,
    input wire logic ldValid,
    input wire logic [1:0] ldSize,
    input wire logic [31:0] ldAddr,
    input wire logic ldStack,
    input wire logic [31:0] ldWord,
    output logic [31:0] ldResult,
    output logic addrErr,
    input wire logic immValid,
    input wire logic immZero,
    input wire logic [7:0] imm8,
    output logic [31:0] immOut,
    input wire logic litValid,
    input wire logic litLong,
    input wire logic [7:0] litDisp,
    input wire logic [31:0] pcIn,
    output logic [31:0] litAddr
);
    // ==========================================================
    // Helpers
    // Widen a source to 40 bits
    function automatic logic [39:0] ext40(input logic [31:0] d, input logic [7:0] g,
                                          input logic isAcc);
        ext40 = isAcc ? {g, d} : {{8{d[31]}}, d};
    endfunction

    // Mask an operand to the active part of its format
    function automatic logic [39:0] fmtMask(input logic [39:0] v, input logic [1:0] f);
        case (f)
            FMT_INT: fmtMask = {v[39:16], 16'h0000};
            FMT_LOG: fmtMask = {8'h00, v[31:16], 16'h0000};
            default: fmtMask = v;
        endcase
    endfunction

    dofr_st_t q, d;
    logic [39:0] opA, opB, res;
    logic carry, ovf, zero, neg, gt, dc;
    logic signed [6:0] ashAmt;
    logic signed [5:0] lshAmt;
    logic misal;
    logic [7:0] ldByte;
    logic [15:0] ldHalf;

    // ==========================================================
    // Datapath: operands, result and flags
    always_comb begin
        opA = fmtMask(ext40(srcA, srcAGuard, srcAIsAcc), opFmt);
        opB = fmtMask(ext40(srcB, 8'h00, 1'b0), opFmt);
        ashAmt = srcB[22:16];
        lshAmt = srcB[21:16];
        carry = 1'b0;
        res = '0;
        case (opCode)
            OP_ADD: {carry, res} = {1'b0, opA} + {1'b0, opB};
            OP_SUB: {carry, res} = {1'b0, opA} - {1'b0, opB};
            OP_ASH: begin
                if (ashAmt >= 0)
                    res = opA << ashAmt[5:0];
                else
                    res = $signed(opA) >>> (7'sd0 - ashAmt);
            end
            default: begin
                if (lshAmt >= 0)
                    res[31:16] = opA[31:16] << lshAmt[4:0];
                else
                    res[31:16] = opA[31:16] >> (6'sd0 - lshAmt);
            end
        endcase
        res = fmtMask(res, opFmt);
        if (opFmt == FMT_LOG) begin
            res[39:32] = 8'h00;
        end
        // Flags see the guard bits except in the logical format
        ovf = (opFmt != FMT_LOG) && (res[39:32] != {8{res[31]}});
        neg = (opFmt == FMT_LOG) ? res[31] : res[39];
        zero = (res == 40'h00_0000_0000);
        gt = !neg && !zero;
        case (q.cr[3:1])
            3'h0: dc = carry;
            3'h1: dc = neg;
            3'h2: dc = zero;
            3'h3: dc = ovf;
            3'h4: dc = gt;
            3'h5: dc = !neg;
            default: dc = 1'b0;
        endcase
    end

    // ==========================================================
    // Memory load alignment and extension
    always_comb begin
        misal = ((ldSize == SZ_W) && ldAddr[0]) ||
                ((ldSize == SZ_L) && (ldAddr[1:0] != 2'h0));
        if (ldStack && (ldSize != SZ_L))
            misal = 1'b1;
        ldByte = ldWord[8'(31 - 8 * ldAddr[1:0]) -: 8];
        ldHalf = ldAddr[1] ? ldWord[15:0] : ldWord[31:16];
    end

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.addrErr = 1'b0;
        d.shiftBad = 1'b0;
        case (q.st)
            DOFR_BOOT_PC: begin
                if (vecAck) begin
                    d.pc = vecData;
                    d.st = DOFR_BOOT_SP;
                end
            end
            DOFR_BOOT_SP: begin
                if (vecAck) begin
                    d.sp = vecData;
                    d.st = DOFR_RUN;
                end
            end
            DOFR_RUN: d.st = DOFR_RUN;
            default: d.st = DOFR_BOOT_PC;
        endcase
        // Register writes
        if (regWr) begin
            case (regAddr)
                ADDR_SR: d.sr = regWdata & SR_WMASK;
                ADDR_CR: d.cr = {24'h00_0000, regWdata[7:0]};
                ADDR_VBR: d.vector_base_register = regWdata;
                ADDR_PC: d.pc = regWdata;
                ADDR_SP: d.sp = regWdata;
                default: d.vector_base_register = q.vector_base_register;
            endcase
        end
        // Operation results override a same-cycle flag write
        if (opValid) begin
            d.acc = res;
            d.cr[CR_GT] = gt;
            d.cr[CR_Z] = zero;
            d.cr[CR_N] = neg;
            d.cr[CR_V] = ovf;
            d.cr[CR_DC] = dc;
            if (opCode == OP_ASH)
                d.shiftBad = (ashAmt < 7'(ASH_MIN)) || (ashAmt > 7'(ASH_MAX));
            else if (opCode == OP_LSH)
                d.shiftBad = (lshAmt < 6'(LSH_MIN)) || (lshAmt > 6'(LSH_MAX));
        end
        // Register reads
        case (regAddr)
            ADDR_SR: d.rdata = q.sr;
            ADDR_CR: d.rdata = q.cr;
            ADDR_VBR: d.rdata = q.vector_base_register;
            ADDR_ACCLO: d.rdata = q.acc[31:0];
            ADDR_ACCG: d.rdata = {24'h00_0000, q.acc[39:32]};
            ADDR_PC: d.rdata = q.pc;
            ADDR_SP: d.rdata = q.sp;
            default: d.rdata = 32'h0000_0000;
        endcase
        if (!regRd)
            d.rdata = 32'h0000_0000;
        // Loads
        if (ldValid) begin
            d.addrErr = misal;
            case (ldSize)
                SZ_B: d.ld = {{24{ldByte[7]}}, ldByte};
                SZ_W: d.ld = {{16{ldHalf[15]}}, ldHalf};
                default: d.ld = ldWord;
            endcase
        end
        // Byte immediates
        if (immValid) begin
            if (immZero)
                d.imm = {24'h00_0000, imm8};
            else
                d.imm = {{24{imm8[7]}}, imm8};
        end
        // Table address for wide immediates
        if (litValid) begin
            if (litLong)
                d.lit = (pcIn & 32'hFFFF_FFFC) + {22'h00_0000, litDisp, 2'h0};
            else
                d.lit = pcIn + {23'h00_0000, litDisp, 1'h0};
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.st <= DOFR_BOOT_PC;
            q.sr <= SR_RST;
            q.cr <= CR_RST;
            q.vector_base_register <= VBR_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign vecRd = (q.st != DOFR_RUN);
    assign vecAddr = (q.st == DOFR_BOOT_SP) ? VEC_SP_ADDR : VEC_PC_ADDR;
    assign bootDone = (q.st == DOFR_RUN);
    assign regRdata = q.rdata;
    assign accOut = q.acc;
    assign crOut = q.cr;
    assign srOut = q.sr;
    assign shiftBad = q.shiftBad;
    assign ldResult = q.ld;
    assign addrErr = q.addrErr;
    assign immOut = q.imm;
    assign litAddr = q.lit;

    // ==========================================================
    // Assertions
    property p_ovf;
        @(posedge clk) disable iff (!rstn)
        opValid && (opFmt == FMT_FIX) |=>
            crOut[CR_V] == (accOut[39:32] != {8{accOut[31]}});
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
    property p_neg;
        @(posedge clk) disable iff (!rstn)
        opValid && (opFmt == FMT_FIX) |=> crOut[CR_N] == accOut[39];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");
    property p_srrst;
        @(posedge clk) !rstn |=> srOut == SR_RST;
    endproperty
    a_srrst: assert property (p_srrst) else $error("status reset wrong");
    property p_crrst;
        @(posedge clk) !rstn |=> (crOut == 32'h0000_0000) && !bootDone;
    endproperty
    a_crrst: assert property (p_crrst) else $error("condition reset wrong");
    property p_boot;
        @(posedge clk) disable iff (!rstn)
        vecRd && vecAck && (vecAddr == VEC_PC_ADDR) |=> q.pc == $past(vecData);
    endproperty
    a_boot: assert property (p_boot) else $error("pc not loaded");
    property p_ldb;
        @(posedge clk) disable iff (!rstn)
        ldValid && (ldSize == SZ_B) |=> ldResult[31:8] == {24{ldResult[7]}};
    endproperty
    a_ldb: assert property (p_ldb) else $error("byte not sign-extended");
    property p_al;
        @(posedge clk) disable iff (!rstn)
        ldValid && (ldSize == SZ_L) && (ldAddr[1:0] != 2'h0) |=>
            addrErr ##1 (!addrErr || $past(ldValid));
    endproperty
    a_al: assert property (p_al) else $error("missing address error");
    property p_stk;
        @(posedge clk) disable iff (!rstn)
        ldValid && ldStack && (ldSize != SZ_L) |=> addrErr;
    endproperty
    a_stk: assert property (p_stk) else $error("stack access not refused");
    property p_imm;
        @(posedge clk) disable iff (!rstn)
        immValid |=> immOut == ($past(immZero) ? {24'h00_0000, $past(imm8)}
                                : {{24{$past(imm8[7])}}, $past(imm8)});
    endproperty
    a_imm: assert property (p_imm) else $error("immediate extension wrong");
    property p_ash;
        @(posedge clk) disable iff (!rstn)
        opValid && (opCode == OP_ASH) && ($signed(srcB[22:16]) > 7'sd32) |=> shiftBad;
    endproperty
    a_ash: assert property (p_ash) else $error("bad shift not flagged");
    property p_lsh;
        @(posedge clk) disable iff (!rstn)
        opValid && (opCode == OP_LSH) && ($signed(srcB[21:16]) < -6'sd16) |=> shiftBad;
    endproperty
    a_lsh: assert property (p_lsh) else $error("bad logical shift not flagged");
    property p_logf;
        @(posedge clk) disable iff (!rstn)
        opValid && (opFmt == FMT_LOG) |=>
            (accOut[39:32] == 8'h00) && (accOut[15:0] == 16'h0000) && !crOut[CR_V];
    endproperty
    a_logf: assert property (p_logf) else $error("logical result not cleared");
    property p_intf;
        @(posedge clk) disable iff (!rstn)
        opValid && (opFmt == FMT_INT) |=> accOut[15:0] == 16'h0000;
    endproperty
    a_intf: assert property (p_intf) else $error("integer low word not cleared");
    property p_ldw;
        @(posedge clk) disable iff (!rstn)
        ldValid && (ldSize == SZ_W) |=> ldResult[31:16] == {16{ldResult[15]}};
    endproperty
    a_ldw: assert property (p_ldw) else $error("word not sign-extended");
    property p_bootsp;
        @(posedge clk) disable iff (!rstn)
        vecRd && vecAck && (vecAddr == VEC_SP_ADDR) |=> (q.sp == $past(vecData)) && bootDone;
    endproperty
    a_bootsp: assert property (p_bootsp) else $error("sp not loaded");
    c_boot: cover property (@(posedge clk) disable iff (!rstn) $rose(bootDone));
    c_ovf: cover property (@(posedge clk) disable iff (!rstn) opValid ##1 crOut[CR_V]);
    c_err: cover property (@(posedge clk) disable iff (!rstn) $rose(addrErr));
    c_shbad: cover property (@(posedge clk) disable iff (!rstn) opValid ##1 shiftBad);
    c_stack: cover property (@(posedge clk) disable iff (!rstn) ldValid && ldStack ##1 addrErr);
endmodule
`default_nettype wire

// >>> verification/dofr_vec_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Vector table model: answers boot fetches after a set delay
module dofr_vec_mem
    import dofr_pkg::*;
#(
    parameter logic [31:0] PC_VEC = 32'h0000_1000,
    parameter logic [31:0] SP_VEC = 32'h0000_7FF0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] delay,
    input wire logic vecRd,
    input wire logic [31:0] vecAddr,
    output logic vecAck,
    output logic [31:0] vecData
);
    logic [3:0] waitCnt;
    // One-cycle ack; data inverted each cycle while idle or after the ack, held while counting the delay
    always @(posedge clk) begin
        if (!rstn) begin
            vecAck <= 1'b0;
            vecData <= 32'h5A5A_A5A5;
            waitCnt <= 4'h0;
        end else if (vecAck || !vecRd) begin
            vecAck <= 1'b0;
            vecData <= ~vecData;
            waitCnt <= 4'h0;
        end else if (waitCnt == delay) begin
            vecAck <= 1'b1;
            vecData <= (vecAddr == VEC_SP_ADDR) ? SP_VEC : PC_VEC;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_dsp_operand_format_and_reset.sv
`timescale 1ns/100ps
`default_nettype none
module tb_dsp_operand_format_and_reset;
    import dofr_pkg::*;
    localparam logic [31:0] PCV = 32'h0000_1000;
    localparam logic [31:0] SPV = 32'h0000_7FF0;
    localparam logic [31:0] LDW = 32'h8812_F07F;
    logic clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, vecRd, vecAck, bootDone;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000, regRdata, vecAddr, vecData;
    logic [3:0] memDelay = 4'h0;
    logic opValid = 1'b0, srcAIsAcc = 1'b0, shiftBad;
    logic [1:0] opCode = 2'h0, opFmt = 2'h0, ldSize = 2'h0;
    logic [31:0] srcA = 32'h0000_0000, srcB = 32'h0000_0000, crOut, srOut;
    logic [7:0] srcAGuard = 8'h00, imm8 = 8'h00, litDisp = 8'h00;
    logic [39:0] accOut;
    logic ldValid = 1'b0, ldStack = 1'b0, addrErr, immValid = 1'b0, immZero = 1'b0;
    logic [31:0] ldAddr = 32'h0000_0000, ldWord = 32'h0000_0000, ldResult, immOut;
    logic litValid = 1'b0, litLong = 1'b0;
    logic [31:0] pcIn = 32'h0000_0000, litAddr;
    logic [6:0] shAmt [6] = '{7'h20, 7'h21, 7'h60, 7'h5F, 7'h3F, 7'h40};
    logic [5:0] lsAmt [6] = '{6'h10, 6'h11, 6'h30, 6'h2F, 6'h1F, 6'h20};
    int failures = 0;
    int cmpCount = 0;
    // ==========================================================
    // Clock, design and vector table
    always #10 clk = ~clk;
    dofr_unit uut (.clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .vecRd,
        .vecAddr, .vecAck, .vecData, .bootDone, .opValid, .opCode, .opFmt, .srcA,
        .srcAGuard, .srcAIsAcc, .srcB, .accOut, .crOut, .srOut, .shiftBad, .ldValid,
        .ldSize, .ldAddr, .ldStack, .ldWord, .ldResult, .addrErr, .immValid, .immZero,
        .imm8, .immOut, .litValid, .litLong, .litDisp, .pcIn, .litAddr);
    dofr_vec_mem #(.PC_VEC(PCV), .SP_VEC(SPV)) mem (.clk, .rstn, .delay(memDelay), .vecRd,
        .vecAddr, .vecAck, .vecData);
    // ==========================================================
    // Shared tasks
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        cmpCount++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic do_reset(input logic [3:0] dly);
        int n;
        n = 0;
        @(posedge clk);
        rstn <= 1'b0;
        memDelay <= dly;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        while (bootDone !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 60) begin
            failures++;
            $display("ERROR bootDone expected 1 seen %b", bootDone);
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(nm, 40'(e), 40'(regRdata & m));
    endtask
    task automatic alu(input logic [1:0] c, input logic [1:0] f, input logic [31:0] a,
            input logic [7:0] g, input logic ac, input logic [31:0] b,
            input logic [39:0] ea, input logic [3:0] ef, input logic full, input logic eb);
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= c;
        opFmt <= f;
        srcA <= a;
        srcAGuard <= g;
        srcAIsAcc <= ac;
        srcB <= b;
        @(posedge clk);
        opValid <= 1'b0;
        #1;
        chk("shiftBad", 40'(eb), 40'(shiftBad));
        if (full) begin
            chk("accOut", ea, accOut);
            chk("crFlags", 40'(ef), 40'(crOut[7:4]));
        end
    endtask
    task automatic ldc(input logic [1:0] sz, input logic [31:0] a, input logic st,
            input logic [31:0] ev, input logic ee);
        @(posedge clk);
        ldValid <= 1'b1;
        ldSize <= sz;
        ldAddr <= a;
        ldStack <= st;
        ldWord <= LDW;
        @(posedge clk);
        ldValid <= 1'b0;
        #1;
        chk("addrErr", 40'(ee), 40'(addrErr));
        if (!ee) chk("ldResult", 40'(ev), 40'(ldResult));
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset_state();
        rdc("sr", ADDR_SR, 32'hFFFF_FFFC, 32'h0000_00F0);
        chk("srOut", 40'h00_0000_00F0, 40'(srOut & 32'hFFFF_FFFC));
        rdc("cr", ADDR_CR, 32'hFFFF_FFFF, 32'h0000_0000);
        rdc("vbr", ADDR_VBR, 32'hFFFF_FFFF, 32'h0000_0000);
        rdc("pc", ADDR_PC, 32'hFFFF_FFFF, PCV);
        rdc("sp", ADDR_SP, 32'hFFFF_FFFF, SPV);
        rdc("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("test reset_state done");
    endtask
    task automatic t_rereset();
        wr(ADDR_SR, 32'hFFFF_FFFF);
        wr(ADDR_CR, 32'hFFFF_FFFF);
        wr(ADDR_VBR, 32'hFFFF_FFFF);
        wr(ADDR_PC, 32'hFFFF_FFFF);
        wr(ADDR_SP, 32'hFFFF_FFFF);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc("srWr", ADDR_SR, 32'hFFFF_FFFF, 32'h0FFF_0CFF);
        rdc("crWr", ADDR_CR, 32'hFFFF_FFFF, 32'h0000_00FF);
        rdc("vbrWr", ADDR_VBR, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        rdc("pcWr", ADDR_PC, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        rdc("spWr", ADDR_SP, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        rdc("unmappedWr", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        do_reset(4'h3);
        t_reset_state();
        $display("test rereset done");
    endtask
    task automatic t_load();
        logic [7:0] b;
        logic [15:0] h;
        for (int i = 0; i < 4; i++) begin
            b = LDW[31 - 8 * i -: 8];
            h = i[1] ? LDW[15:0] : LDW[31:16];
            ldc(SZ_B, 32'(i), 1'b0, {{24{b[7]}}, b}, 1'b0);
            ldc(SZ_W, 32'(i), 1'b0, {{16{h[15]}}, h}, i[0]);
            ldc(SZ_L, 32'(i) + 32'h100, 1'b0, LDW, i[1:0] != 2'b00);
        end
        ldc(SZ_W, 32'h0, 1'b1, LDW, 1'b1);
        ldc(SZ_L, 32'h6, 1'b1, LDW, 1'b1);
        ldc(SZ_L, 32'h8, 1'b1, LDW, 1'b0);
        $display("test load done");
    endtask
    task automatic t_imm_lit();
        logic [39:0] ei;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            immValid <= 1'b1;
            immZero <= i[0];
            imm8 <= i[1] ? 8'h7F : 8'h80;
            litValid <= 1'b1;
            litLong <= i[0];
            litDisp <= 8'h03;
            pcIn <= 32'h0000_1002;
            @(posedge clk);
            immValid <= 1'b0;
            litValid <= 1'b0;
            #1;
            ei = i[1] ? 40'h7F : (i[0] ? 40'h80 : 40'hFFFF_FF80);
            chk("immOut", ei, 40'(immOut));
            chk("litAddr", i[0] ? 40'h100C : 40'h1008, 40'(litAddr));
        end
        $display("test imm_lit done");
    endtask
    task automatic t_alu();
        alu(OP_ADD, FMT_FIX, 32'h7FFF_FFFF, 8'h00, 1'b0, 32'h1,
            40'h00_8000_0000, 4'h9, 1'b1, 1'b0);
        rdc("accLo", ADDR_ACCLO, 32'hFFFF_FFFF, 32'h8000_0000);
        alu(OP_SUB, FMT_FIX, 32'h0, 8'h00, 1'b0, 32'h1,
            40'hFF_FFFF_FFFF, 4'h2, 1'b1, 1'b0);
        alu(OP_ADD, FMT_FIX, 32'h0, 8'h80, 1'b1, 32'h0,
            40'h80_0000_0000, 4'h3, 1'b1, 1'b0);
        rdc("accG", ADDR_ACCG, 32'hFFFF_FFFF, 32'h0000_0080);
        alu(OP_ADD, FMT_FIX, 32'h8000_0000, 8'h00, 1'b0, 32'h0,
            40'hFF_8000_0000, 4'h2, 1'b1, 1'b0);
        alu(OP_SUB, FMT_FIX, 32'h5, 8'h00, 1'b0, 32'h5, 40'h0, 4'h4, 1'b1, 1'b0);
        alu(OP_ADD, FMT_INT, 32'h0001_8000, 8'h00, 1'b0, 32'h1,
            40'h00_0001_0000, 4'h8, 1'b1, 1'b0);
        alu(OP_ADD, FMT_LOG, 32'h8000_FFFF, 8'h00, 1'b0, 32'h0,
            40'h00_8000_0000, 4'h2, 1'b1, 1'b0);
        alu(OP_ASH, FMT_FIX, 32'h1, 8'h00, 1'b0, 32'h0004_0000,
            40'h00_0000_0010, 4'h8, 1'b1, 1'b0);
        alu(OP_ASH, FMT_FIX, 32'h8000_0000, 8'h00, 1'b0, 32'h007F_0000,
            40'hFF_C000_0000, 4'h2, 1'b1, 1'b0);
        alu(OP_LSH, FMT_LOG, 32'h0001_0000, 8'h00, 1'b0, 32'h0003_0000,
            40'h00_0008_0000, 4'h8, 1'b1, 1'b0);
        wr(ADDR_CR, 32'h0000_0002);
        alu(OP_SUB, FMT_FIX, 32'h0, 8'h00, 1'b0, 32'h1,
            40'hFF_FFFF_FFFF, 4'h2, 1'b1, 1'b0);
        chk("dc", 40'h1, 40'(crOut[CR_DC]));
        for (int i = 0; i < 6; i++) begin
            alu(OP_ASH, FMT_FIX, 32'h1, 8'h00, 1'b0, {9'h0, shAmt[i], 16'h0},
                40'h0, 4'h0, 1'b0, i[0] || i > 3);
            alu(OP_LSH, FMT_LOG, 32'h1, 8'h00, 1'b0, {10'h0, lsAmt[i], 16'h0},
                40'h0, 4'h0, 1'b0, i[0] || i > 3);
        end
        $display("test alu done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        do_reset(4'h0);
        t_reset_state();
        t_load();
        t_imm_lit();
        t_alu();
        t_rereset();
        end_of_test();
    end
endmodule
`default_nettype wire
